//--- core/ssd_consts.vh
// Register offsets, field positions, reset values and timing counts of the stall detector
`ifndef SSD_CONSTS_VH
`define SSD_CONSTS_VH
// Register byte offsets
`define SSD_OFS_CTRL 12'h000
`define SSD_OFS_CNTCTL 12'h004
`define SSD_OFS_FLAG 12'h008
`define SSD_OFS_COUNT 12'h00C
`define SSD_OFS_ACC 12'h010
// Coil control register fields
`define SSD_CTRL_STEP_LO 0
`define SSD_CTRL_DRIVE_COIL_CONTROL 2
`define SSD_CTRL_ITG 3
`define SSD_CTRL_CLKS_LO 4
`define SSD_CTRL_WAI 6
`define SSD_CTRL_CPU 7
`define SSD_CTRL_RETURN_TO_ZERO_ENABLE 8
`define SSD_CTRL_RECIRCULATION_SELECT 9
`define SSD_CTRL_SMS 10
// Counter control register fields
`define SSD_CC_OVIE 0
`define SSD_CC_EN 2
`define SSD_CC_FLOAD 3
`define SSD_CC_PRE 4
`define SSD_CC_RDLD 5
`define SSD_CC_MOD 6
`define SSD_CC_UFIE 7
// Flag register fields
`define SSD_FLG_UF 7
`define SSD_FLG_OV 0
// Reset and limit values
`define SSD_CNT_PRESET 16'hFFFF
`define SSD_ACC_MAX 16'h7FFF
`define SSD_ACC_MIN 16'h8000
// Prescale divisors
`define SSD_DIV_LO 64
`define SSD_DIV_HI 512
`define SSD_SMP_DIV_BASE 8
// Terminal counts of the prescalers, one less than each divisor
`define SSD_PRE_TOP_LO 9'h03F
`define SSD_PRE_TOP_HI 9'h1FF
`define SSD_SMP_TOP_0 6'h07
`define SSD_SMP_TOP_1 6'h0F
`define SSD_SMP_TOP_2 6'h1F
`define SSD_SMP_TOP_3 6'h3F
`endif

//--- core/ssd_core.v
// Stepper stall detector core: APB registers, down-counter, accumulator, coil routing
`timescale 1ns/1ps
`include "ssd_consts.vh"

module ssd_core (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Power management
    input wire stop_mode,
    input wire wait_mode,
    // Sigma-delta converter
    input wire sd_sample,
    output reg sd_reset,
    output reg sd_power_up,
    // Coil routing: 2 bits per coil, 00 off, 01 drive, 10 recirculate, 11 converter
    output reg [1:0] sin_coil_mode,
    output reg [1:0] cos_coil_mode,
    output reg [1:0] step_state,
    output reg coil_polarity,
    output reg motor_select,
    // Interrupts
    output reg underflow_irq,
    output reg overflow_irq
);

    // Coil routing codes
    localparam [1:0] COIL_OFF = 2'h0;
    localparam [1:0] COIL_DRIVE = 2'h1;
    localparam [1:0] COIL_RECIRC = 2'h2;
    localparam [1:0] COIL_CONV = 2'h3;

    reg [10:0] ctrl_q;
    reg [7:0] cntctl_q;
    reg flag_uf_q;
    reg flag_ov_q;
    reg [15:0] count_q;
    reg [15:0] load_q;
    reg [15:0] acc_q;
    reg [8:0] pre_cnt_q;
    reg [5:0] smp_cnt_q;
    reg [1:0] clks_act_q;
    reg pre_act_q;

    wire wr = psel & penable & pwrite;
    wire wr_ctrl = wr & (paddr == `SSD_OFS_CTRL);
    wire wr_cc = wr & (paddr == `SSD_OFS_CNTCTL);
    wire wr_flag = wr & (paddr == `SSD_OFS_FLAG);
    wire wr_cnt = wr & (paddr == `SSD_OFS_COUNT);
    wire integrate_control = ctrl_q[`SSD_CTRL_ITG];
    wire drive_coil_control = ctrl_q[`SSD_CTRL_DRIVE_COIL_CONTROL];
    wire return_to_zero_enable = ctrl_q[`SSD_CTRL_RETURN_TO_ZERO_ENABLE];
    wire cnt_en = cntctl_q[`SSD_CC_EN];
    wire modulus_mode = cntctl_q[`SSD_CC_MOD];
    // Low power freezes the prescaler and powers the converter down
    wire lp_halt = stop_mode | (wait_mode & ctrl_q[`SSD_CTRL_WAI]);
    wire conv_on = ctrl_q[`SSD_CTRL_CPU] & ~lp_halt;

    // Counter prescaler; the divisor only changes at a load, so no runt tick
    wire [8:0] pre_top = pre_act_q ? `SSD_PRE_TOP_HI : `SSD_PRE_TOP_LO;
    wire cnt_tick = cnt_en & ~lp_halt & (pre_cnt_q >= pre_top);
    // A load restarts the prescaler so the first tick is a full period away
    wire force_ld = wr_cc & pwdata[`SSD_CC_FLOAD];
    wire cnt_load = cnt_en & (force_ld | (wr_cnt & ~modulus_mode));

    // Sample prescaler: 8 << field
    reg [5:0] smp_top;
    always @* begin
        case (clks_act_q)
            2'h0: smp_top = `SSD_SMP_TOP_0;
            2'h1: smp_top = `SSD_SMP_TOP_1;
            2'h2: smp_top = `SSD_SMP_TOP_2;
            default: smp_top = `SSD_SMP_TOP_3;
        endcase
    end
    wire smp_tick = integrate_control & conv_on & (smp_cnt_q >= smp_top);

    // Underflow: count reaches zero from one on a tick
    wire uf_event = cnt_tick & (count_q == 16'h0001);
    wire [16:0] acc_nx_p = {acc_q[15], acc_q} + 17'h00001;
    wire [16:0] acc_nx_m = {acc_q[15], acc_q} - 17'h00001;
    wire ov_pos = smp_tick & sd_sample & (acc_q == `SSD_ACC_MAX);
    wire ov_neg = smp_tick & ~sd_sample & (acc_q == `SSD_ACC_MIN);
    wire ov_event = ov_pos | ov_neg;

    // Control registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 11'h000;
            cntctl_q <= 8'h00;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata[10:0];
            end
            if (wr_cc) begin
                cntctl_q <= pwdata[7:0] & ~(8'h01 << `SSD_CC_FLOAD);
            end
        end
    end

    // Sticky flags; a set in the clear cycle wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_uf_q <= 1'b0;
            flag_ov_q <= 1'b0;
        end else begin
            flag_uf_q <= uf_event | (flag_uf_q & ~(wr_flag & pwdata[`SSD_FLG_UF]));
            flag_ov_q <= ov_event | (flag_ov_q & ~(wr_flag & pwdata[`SSD_FLG_OV]));
        end
    end

    // Prescalers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_q <= 9'h000;
            smp_cnt_q <= 6'h00;
            clks_act_q <= 2'h0;
        end else begin
            if (!cnt_en || cnt_tick || cnt_load) begin
                pre_cnt_q <= 9'h000;
            end else if (!lp_halt) begin
                pre_cnt_q <= pre_cnt_q + 9'h001;
            end
            // Rate field takes effect only while integration is off
            // A field written together with the integrate bit still applies
            if (!integrate_control) begin
                clks_act_q <= wr_ctrl ? pwdata[`SSD_CTRL_CLKS_LO +: 2] :
                    ctrl_q[`SSD_CTRL_CLKS_LO +: 2];
            end
            if (!integrate_control || smp_tick) begin
                smp_cnt_q <= 6'h00;
            end else if (conv_on) begin
                smp_cnt_q <= smp_cnt_q + 6'h01;
            end
        end
    end

    // Down-counter and load register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= `SSD_CNT_PRESET;
            load_q <= 16'h0000;
            pre_act_q <= 1'b0;
        end else begin
            if (wr_cnt) begin
                load_q <= pwdata[15:0];
            end
            if (!cnt_en) begin
                count_q <= `SSD_CNT_PRESET;
            end else if (wr_cc && pwdata[`SSD_CC_FLOAD]) begin
                count_q <= wr_cnt ? pwdata[15:0] : load_q;
                pre_act_q <= cntctl_q[`SSD_CC_PRE];
            end else if (wr_cnt && !modulus_mode) begin
                count_q <= pwdata[15:0];
                pre_act_q <= cntctl_q[`SSD_CC_PRE];
            end else if (cnt_tick) begin
                if (count_q != 16'h0000) begin
                    count_q <= count_q - 16'h0001;
                end else if (modulus_mode) begin
                    count_q <= load_q;
                    pre_act_q <= cntctl_q[`SSD_CC_PRE];
                end
            end
        end
    end

    // Integration accumulator
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= 16'h0000;
        end else if (!integrate_control) begin
            acc_q <= 16'h0000;
        end else if (smp_tick && !ov_event) begin
            acc_q <= sd_sample ? acc_nx_p[15:0] : acc_nx_m[15:0];
        end
    end

    // Coil routing per mode; first coil is cos in even steps, sin in odd
    reg [1:0] meas_mode;
    reg [1:0] other_mode;
    always @* begin
        case ({integrate_control, drive_coil_control})
            2'b00: begin
                meas_mode = COIL_RECIRC;
                other_mode = COIL_OFF;
            end
            2'b01: begin
                meas_mode = COIL_RECIRC;
                other_mode = COIL_DRIVE;
            end
            2'b10: begin
                meas_mode = COIL_CONV;
                other_mode = COIL_OFF;
            end
            default: begin
                meas_mode = COIL_CONV;
                other_mode = COIL_DRIVE;
            end
        endcase
        if (!return_to_zero_enable) begin
            meas_mode = integrate_control ? COIL_CONV : COIL_OFF;
            other_mode = COIL_OFF;
        end else if (lp_halt) begin
            meas_mode = COIL_RECIRC;
            other_mode = COIL_RECIRC;
        end
    end

    // Registered pin and interrupt outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sin_coil_mode <= COIL_OFF;
            cos_coil_mode <= COIL_OFF;
            step_state <= 2'h0;
            coil_polarity <= 1'b0;
            motor_select <= 1'b0;
            sd_reset <= 1'b1;
            sd_power_up <= 1'b0;
            underflow_irq <= 1'b0;
            overflow_irq <= 1'b0;
        end else begin
            step_state <= ctrl_q[`SSD_CTRL_STEP_LO +: 2];
            sin_coil_mode <= ctrl_q[`SSD_CTRL_STEP_LO] ? meas_mode : other_mode;
            cos_coil_mode <= ctrl_q[`SSD_CTRL_STEP_LO] ? other_mode : meas_mode;
            coil_polarity <= ctrl_q[`SSD_CTRL_STEP_LO + 1] ^ ctrl_q[`SSD_CTRL_RECIRCULATION_SELECT];
            motor_select <= ctrl_q[`SSD_CTRL_SMS];
            sd_reset <= ~integrate_control;
            sd_power_up <= conv_on;
            underflow_irq <= flag_uf_q & cntctl_q[`SSD_CC_UFIE];
            overflow_irq <= flag_ov_q & cntctl_q[`SSD_CC_OVIE];
        end
    end

    // APB: zero wait states, error on unmapped address
    reg [31:0] rd_d;
    reg hit_d;
    always @* begin
        rd_d = 32'h00000000;
        hit_d = 1'b1;
        if (paddr == `SSD_OFS_CTRL) begin
            rd_d = {21'h000000, ctrl_q};
        end else if (paddr == `SSD_OFS_CNTCTL) begin
            rd_d = {24'h000000, cntctl_q};
        end else if (paddr == `SSD_OFS_FLAG) begin
            rd_d = {24'h000000, flag_uf_q, 6'h00, flag_ov_q};
        end else if (paddr == `SSD_OFS_COUNT) begin
            rd_d = {16'h0000, cntctl_q[`SSD_CC_RDLD] ? load_q : count_q};
        end else if (paddr == `SSD_OFS_ACC) begin
            rd_d = {16'h0000, acc_q};
        end else begin
            hit_d = 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit_d;
            prdata <= (psel & ~penable & ~pwrite) ? rd_d : 32'h00000000;
        end
    end

endmodule

//--- dv/ssd_asserts.sv
// Checker of bus timing, coil routing and interrupt release of the stall detector
`timescale 1ns/1ps
module ssd_asserts (
    // Clock, reset and bus
    input wire pclk, presetn, psel, penable, pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready, pslverr,
    // Power, converter and coils
    input wire stop_mode, sd_reset, sd_power_up,
    input wire [1:0] sin_coil_mode, cos_coil_mode, step_state,
    // Interrupts
    input wire underflow_irq, overflow_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Write seen at an access edge; irq release must trace back to one
    wire wr_w = psel && penable && pwrite;
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence bad_s;
        setup_s ##0 (paddr > 12'h010);
    endsequence
    wire sin_conv = sin_coil_mode == 2'h3;
    wire cos_conv = cos_coil_mode == 2'h3;
    pready_wait_a: assert property (setup_s |=> pready) else $error("no answer");
    access_only_a: assert property (pready |-> psel && penable) else $error("stray ready");
    unmapped_err_a: assert property (bad_s |=> pslverr && prdata == 32'h0) else $error("slverr");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("rdata idle");
    uf_drop_a: assert property ($fell(underflow_irq) |-> $past(wr_w) || $past(wr_w, 2))
        else $error("uf irq fell");
    ov_drop_a: assert property ($fell(overflow_irq) |-> $past(wr_w) || $past(wr_w, 2))
        else $error("ov irq fell");
    lp_off_a: assert property ($past(stop_mode) |-> !sd_power_up) else $error("stop power");
    conv_itg_a: assert property (sin_conv || cos_conv |-> !sd_reset && !(sin_conv && cos_conv))
        else $error("conv route");
    recirc_blank_a: assert property (sin_coil_mode == 2'h2 || cos_coil_mode == 2'h2
        |-> sd_reset || !sd_power_up) else $error("recirc");
    step_hold_a: assert property (!$stable(step_state) |-> $past(wr_w) || $past(wr_w, 2))
        else $error("step moved");
endmodule
bind ssd_core ssd_asserts ssd_asserts_i (.*);

//--- dv/ssd_coil_model.sv
// Coil and converter model: back-EMF sample stream of the measured coil
`timescale 1ns/1ps
module ssd_coil_model (
    // Clock and coil routing
    input wire pclk,
    input wire [1:0] sin_coil_mode,
    input wire [1:0] cos_coil_mode,
    // Direction of back-EMF
    input wire emf_dir,
    // Converter sample
    output reg sd_sample
);
    initial sd_sample = 1'b0;
    // Unrouted converter toggles so no stale level looks like EMF
    always @(posedge pclk) begin
        if (sin_coil_mode == 2'h3 || cos_coil_mode == 2'h3) sd_sample <= emf_dir;
        else sd_sample <= ~sd_sample;
    end
endmodule

//--- dv/ssd_tb.sv
// Testbench of the stall detector core
`timescale 1ns/1ps
`include "ssd_consts.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module testbench;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    reg stop_mode = 0, wait_mode = 0, emf_dir = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, rv, s = 32'hB9CE559E;
    reg [33:0] n;
    reg [3:0] ex;
    reg [1:0] mt, ot;
    wire [31:0] prdata;
    wire pready, pslverr, sd_sample, sd_reset, sd_power_up, coil_polarity;
    wire motor_select, underflow_irq, overflow_irq;
    wire [1:0] sin_coil_mode, cos_coil_mode, step_state;
    reg [33:0] q[$];
    int err_total = 0, check_count = 0, r, st, m;
    ssd_core ssd_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stop_mode(stop_mode), .wait_mode(wait_mode),
        .sd_sample(sd_sample), .sd_reset(sd_reset), .sd_power_up(sd_power_up),
        .sin_coil_mode(sin_coil_mode), .cos_coil_mode(cos_coil_mode),
        .step_state(step_state), .coil_polarity(coil_polarity),
        .motor_select(motor_select), .underflow_irq(underflow_irq),
        .overflow_irq(overflow_irq));
    ssd_coil_model ssd_coil_model_i (.pclk(pclk), .sin_coil_mode(sin_coil_mode),
        .cos_coil_mode(cos_coil_mode), .emf_dir(emf_dir), .sd_sample(sd_sample));
    initial begin
        forever #2 pclk = ~pclk;
    end
    task stop_test;
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    function [31:0] xs(input [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // One APB transfer; idle edge after it keeps drives one per time step
    task ap(input w, input [11:0] a, input [31:0] d, input [33:0] e);
        int k;
        if (!w) q.push_back(e);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin err_total++; stop_test; end
        rv = prdata;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task wr(input [11:0] a, input [31:0] d); ap(1, a, d, 0); endtask
    task rd(input [11:0] a, input [32:0] e); ap(0, a, 0, {1'b1, e}); endtask
    task rdx(input [11:0] a); ap(0, a, 0, 0); endtask
    task wt(input int c); repeat (c) @(posedge pclk); endtask
    // Read results matched against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            n = q.pop_front();
            if (n[33]) `CHK({pslverr, prdata}, n[32:0])
        end
    end
    initial begin
        wt(3);
        presetn <= 1;
        wt(1);
        rd(`SSD_OFS_FLAG, 0);
        rd(`SSD_OFS_COUNT, 33'hFFFF);
        wr(`SSD_OFS_ACC, 32'h1234);
        rd(`SSD_OFS_ACC, 0);
        rd(12'h014, 33'h100000000);
        wr(`SSD_OFS_CNTCTL, 32'h24);
        for (r = 0; r < 4; r++) begin
            s = xs(s);
            wr(`SSD_OFS_COUNT, s[15:0] | 16'h1);
            rd(`SSD_OFS_COUNT, s[15:0] | 16'h1);
        end
        wr(`SSD_OFS_CNTCTL, 32'h84);
        wr(`SSD_OFS_COUNT, 3);
        wt(300);
        rd(`SSD_OFS_COUNT, 0);
        rd(`SSD_OFS_FLAG, 33'h80);
        `CHK(underflow_irq, 1'b1)
        wr(`SSD_OFS_FLAG, 0);
        rd(`SSD_OFS_FLAG, 33'h80);
        wr(`SSD_OFS_FLAG, 32'h80);
        rd(`SSD_OFS_FLAG, 0);
        `CHK(underflow_irq, 1'b0)
        wr(`SSD_OFS_COUNT, 0);
        wt(200);
        rd(`SSD_OFS_FLAG, 0);
        wr(`SSD_OFS_CNTCTL, 32'h14);
        wr(`SSD_OFS_COUNT, 2);
        wt(400);
        rd(`SSD_OFS_FLAG, 0);
        wt(1100);
        rd(`SSD_OFS_FLAG, 33'h80);
        wr(`SSD_OFS_CNTCTL, 32'h64);
        wr(`SSD_OFS_COUNT, 9);
        rd(`SSD_OFS_COUNT, 9);
        wr(`SSD_OFS_CNTCTL, 32'h5C);
        rd(`SSD_OFS_CNTCTL, 33'h54);
        wr(`SSD_OFS_COUNT, 5);
        rd(`SSD_OFS_COUNT, 9);
        emf_dir <= 1;
        wr(`SSD_OFS_CTRL, 32'h8C);
        wt(200);
        rdx(`SSD_OFS_ACC);
        `CHK(rv[15:0] >= 16'h14 && rv[15:0] <= 16'h1C, 1'b1)
        wr(`SSD_OFS_CTRL, 32'h80);
        rd(`SSD_OFS_ACC, 0);
        `CHK(sd_reset, 1'b1)
        emf_dir <= 0;
        wr(`SSD_OFS_CTRL, 32'hB8);
        wt(640);
        rdx(`SSD_OFS_ACC);
        `CHK(rv[15:0] >= 16'hFFF3 && rv[15:0] <= 16'hFFF8, 1'b1)
        // Every mode at every full step, with and without return enable
        for (r = 0; r < 2; r++) for (st = 0; st < 4; st++) for (m = 0; m < 4; m++) begin
            wr(`SSD_OFS_CTRL, {r[0], 4'h8, m[1:0], st[1:0]});
            wt(3);
            mt = m[1] ? 2'h3 : (r ? 2'h2 : 2'h0);
            ot = (r && m[0]) ? 2'h1 : 2'h0;
            ex = st[0] ? {mt, ot} : {ot, mt};
            `CHK({sin_coil_mode, cos_coil_mode}, ex)
            `CHK(step_state, st[1:0])
        end
        wr(`SSD_OFS_CTRL, 32'h600);
        wt(3);
        `CHK({motor_select, coil_polarity}, 2'b11)
        wr(`SSD_OFS_CTRL, 32'h1C0);
        stop_mode <= 1;
        wt(3);
        `CHK({sin_coil_mode, cos_coil_mode, sd_power_up}, 5'h14)
        stop_mode <= 0;
        wait_mode <= 1;
        wt(3);
        `CHK({sin_coil_mode, cos_coil_mode, sd_power_up}, 5'h14)
        wait_mode <= 0;
        stop_test;
    end
endmodule
